// [design/pmd_cfg.svh]
// Overview of operation
// - Read seen: RAS goes low one clock later.
// - Single read data handed to processor three clocks after RAS falls.
// - Each read gives RAS one precharge clock before and two after.
// - Single read takes six clocks from strobe to end of refill.
// - After a write, hold RAS low in page-mode idle.
// - Leaving page idle for refresh or non-page access raises RAS first.
// - Write after read: no extra precharge, five clocks strobe to strobe end.
// - Same-row write in page idle: RAS held, CAS cycled, three clocks.
// - Page-mode write sequence ends with RAS still low, back in page idle.
// - Different-row write in page idle: raise RAS and CAS, precharge, eight clocks.
// - Read after write gets one extra RAS precharge clock.
// - Quad read throttled: two idle clocks between words, six in all.
// - Controller refreshes DRAM itself, arbitrating against reads and writes.
// - Processor page hint decides whether a write may run in page mode.
// - Partial writes take no extra clocks; byte CAS lanes, no read-modify-write.
`ifndef PMD_CFG_SVH
`define PMD_CFG_SVH

`define PMD_ROW_W        10
`define PMD_COL_W        10
`define PMD_ADDR_W       20
`define PMD_DATA_W       32
`define PMD_LANES        4

`define PMD_CLK_NS       10
`define PMD_REF_NS       15600
`define PMD_REF_CYC      (`PMD_REF_NS / `PMD_CLK_NS)
`define PMD_REF_CNT_W    11

`define PMD_XPRE_LD      3'h1
`define PMD_NPPRE_LD     3'h2
`define PMD_TAIL_LD      3'h1
`define PMD_REFPRE_LD    3'h1
`define PMD_REFHOLD_LD   3'h1
`define PMD_REFEND_LD    3'h1
`define PMD_QUAD_LAST    2'h3

`endif

// [design/pmd_pkg.sv]
`include "pmd_cfg.svh"
package pmd_pkg;

  typedef enum logic [4:0] {
    IDLE, RD_XPRE, RD_ROW, RD_COL, RD_WAIT, RD_GAP, RD_TAIL,
    WR_ROW, WR_CAS, WR_HOLD, WR_END, PG_CAS, PAGE_IDLE, NP_PRE,
    REF_PRE, REF_CAS, REF_RAS, REF_HOLD, REF_END
  } pmd_st_t;

  typedef struct packed {
    logic [`PMD_ROW_W-1:0]  row;
    logic [`PMD_COL_W-1:0]  col;
    logic [`PMD_DATA_W-1:0] wdata;
    logic [`PMD_LANES-1:0]  be;
    logic                   quad;
  } pmd_req_t;

  typedef struct packed {
    pmd_st_t                st;
    logic [2:0]             cnt;
    logic [1:0]             word;
    pmd_req_t               req;
    logic [`PMD_ROW_W-1:0]  last_row;
    logic                   ref_pend;
    logic                   ras_b;
    logic [`PMD_LANES-1:0]  cas_b;
    logic                   we_b;
    logic [`PMD_COL_W-1:0]  dram_addr;
    logic                   dq_oe;
    logic [`PMD_DATA_W-1:0] rd_data;
    logic                   rd_valid;
    logic                   rd_last;
  } pmd_seq_t;

  typedef struct packed {
    logic [`PMD_REF_CNT_W-1:0] cnt;
    logic                      tick;
  } pmd_tmr_t;

endpackage

// [design/pmd_refresh_timer.sv]
`timescale 1ns/1ns
`include "pmd_cfg.svh"
module pmd_refresh_timer (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  output logic      tick
);
  pmd_pkg::pmd_tmr_t s_r;
  pmd_pkg::pmd_tmr_t s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (s_r.cnt == '0) begin
      s_nxt.cnt  = `PMD_REF_CNT_W'(`PMD_REF_CYC - 1);
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;
endmodule

// [design/pmd_sequencer.sv]
`timescale 1ns/1ns
`include "pmd_cfg.svh"
module pmd_sequencer (
  input  wire logic                   sys_clk,
  input  wire logic                   rst_b,
  input  wire logic                   rd_req,
  input  wire logic                   wr_req,
  input  wire logic                   quad_req,
  input  wire logic                   page_hint_output,
  input  wire logic [`PMD_ADDR_W-1:0] cpu_addr,
  input  wire logic [`PMD_DATA_W-1:0] cpu_wdata,
  input  wire logic [`PMD_LANES-1:0]  cpu_be,
  output logic [`PMD_DATA_W-1:0]      rd_data,
  output logic                        rd_valid,
  output logic                        rd_last,
  output logic                        wr_ack,
  output logic                        busy,
  output logic                        ras_b,
  output logic [`PMD_LANES-1:0]       cas_b,
  output logic                        we_b,
  output logic [`PMD_COL_W-1:0]       dram_addr,
  input  wire logic [`PMD_DATA_W-1:0] dram_dq_i,
  output logic [`PMD_DATA_W-1:0]      dram_dq_o,
  output logic                        dram_dq_oe
);
  pmd_pkg::pmd_seq_t s_r;
  pmd_pkg::pmd_seq_t s_nxt;
  logic              ref_tick;
  logic              row_hit;

  pmd_refresh_timer u_timer (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .tick    (ref_tick)
  );

  // Page only when the processor hints it and the row still matches
  assign row_hit = page_hint_output && (cpu_addr[`PMD_ADDR_W-1:`PMD_COL_W] == s_r.last_row);

  always_comb begin
    s_nxt          = s_r;
    s_nxt.rd_valid = 1'b0;
    s_nxt.rd_last  = 1'b0;
    // Tick beats a clear in the same cycle
    if (ref_tick) begin
      s_nxt.ref_pend = 1'b1;
    end
    unique case (s_r.st)
      pmd_pkg::IDLE: begin
        // Refresh first: a late refresh loses data, a late access only waits
        if (s_r.ref_pend) begin
          s_nxt.st = pmd_pkg::REF_CAS;
        end else if (rd_req) begin
          s_nxt.st       = pmd_pkg::RD_ROW;
          s_nxt.word     = '0;
          s_nxt.req.quad = quad_req;
        end else if (wr_req) begin
          s_nxt.st = pmd_pkg::WR_ROW;
        end
      end
      pmd_pkg::PAGE_IDLE: begin
        if (s_r.ref_pend) begin
          s_nxt.st  = pmd_pkg::REF_PRE;
          s_nxt.cnt = `PMD_REFPRE_LD;
        end else if (rd_req) begin
          s_nxt.st       = pmd_pkg::RD_XPRE;
          s_nxt.cnt      = `PMD_XPRE_LD;
          s_nxt.word     = '0;
          s_nxt.req.quad = quad_req;
        end else if (wr_req && row_hit) begin
          s_nxt.st = pmd_pkg::PG_CAS;
        end else if (wr_req) begin
          s_nxt.st  = pmd_pkg::NP_PRE;
          s_nxt.cnt = `PMD_NPPRE_LD;
        end
      end
      pmd_pkg::RD_XPRE: begin
        if (s_r.cnt == '0) begin
          s_nxt.st = pmd_pkg::RD_ROW;
        end else begin
          s_nxt.cnt = s_r.cnt - 1'b1;
        end
      end
      pmd_pkg::RD_ROW: s_nxt.st = pmd_pkg::RD_COL;
      pmd_pkg::RD_COL: s_nxt.st = pmd_pkg::RD_WAIT;
      pmd_pkg::RD_WAIT: begin
        // Word lands three clocks after RAS fell
        s_nxt.rd_data  = dram_dq_i;
        s_nxt.rd_valid = 1'b1;
        if (!s_r.req.quad || s_r.word == `PMD_QUAD_LAST) begin
          s_nxt.rd_last = 1'b1;
          s_nxt.st      = pmd_pkg::RD_TAIL;
          s_nxt.cnt     = `PMD_TAIL_LD;
        end else begin
          s_nxt.st   = pmd_pkg::RD_GAP;
          s_nxt.word = s_r.word + 1'b1;
        end
      end
      pmd_pkg::RD_GAP: s_nxt.st = pmd_pkg::RD_COL;
      pmd_pkg::RD_TAIL: begin
        if (s_r.cnt == '0) begin
          s_nxt.st = pmd_pkg::IDLE;
        end else begin
          s_nxt.cnt = s_r.cnt - 1'b1;
        end
      end
      pmd_pkg::NP_PRE: begin
        if (s_r.cnt == '0) begin
          s_nxt.st = pmd_pkg::WR_ROW;
        end else begin
          s_nxt.cnt = s_r.cnt - 1'b1;
        end
      end
      pmd_pkg::WR_ROW:  s_nxt.st = pmd_pkg::WR_CAS;
      pmd_pkg::WR_CAS:  s_nxt.st = pmd_pkg::WR_HOLD;
      pmd_pkg::WR_HOLD: s_nxt.st = pmd_pkg::WR_END;
      pmd_pkg::PG_CAS:  s_nxt.st = pmd_pkg::WR_END;
      pmd_pkg::WR_END: begin
        s_nxt.st       = pmd_pkg::PAGE_IDLE;
        s_nxt.last_row = s_r.req.row;
      end
      pmd_pkg::REF_PRE: begin
        if (s_r.cnt == '0) begin
          s_nxt.st = pmd_pkg::REF_CAS;
        end else begin
          s_nxt.cnt = s_r.cnt - 1'b1;
        end
      end
      pmd_pkg::REF_CAS: begin
        s_nxt.st       = pmd_pkg::REF_RAS;
        s_nxt.ref_pend = ref_tick;
      end
      pmd_pkg::REF_RAS: begin
        s_nxt.st  = pmd_pkg::REF_HOLD;
        s_nxt.cnt = `PMD_REFHOLD_LD;
      end
      pmd_pkg::REF_HOLD: begin
        if (s_r.cnt == '0) begin
          s_nxt.st  = pmd_pkg::REF_END;
          s_nxt.cnt = `PMD_REFEND_LD;
        end else begin
          s_nxt.cnt = s_r.cnt - 1'b1;
        end
      end
      pmd_pkg::REF_END: begin
        if (s_r.cnt == '0) begin
          s_nxt.st = pmd_pkg::IDLE;
        end else begin
          s_nxt.cnt = s_r.cnt - 1'b1;
        end
      end
      default: s_nxt.st = pmd_pkg::IDLE;
    endcase

    // Capture the request on the cycle it is taken
    if ((s_r.st == pmd_pkg::IDLE || s_r.st == pmd_pkg::PAGE_IDLE) && s_nxt.st != s_r.st) begin
      s_nxt.req.row   = cpu_addr[`PMD_ADDR_W-1:`PMD_COL_W];
      s_nxt.req.col   = cpu_addr[`PMD_COL_W-1:0];
      s_nxt.req.wdata = cpu_wdata;
      s_nxt.req.be    = cpu_be;
    end

    // Pins decoded from the next state so they come straight from flops
    s_nxt.ras_b = 1'b1;
    s_nxt.cas_b = '1;
    s_nxt.we_b  = 1'b1;
    s_nxt.dq_oe = 1'b0;
    s_nxt.dram_addr = s_nxt.req.row;
    unique case (s_nxt.st)
      pmd_pkg::RD_ROW, pmd_pkg::RD_GAP, pmd_pkg::WR_ROW, pmd_pkg::WR_END, pmd_pkg::PAGE_IDLE: begin
        s_nxt.ras_b = 1'b0;
      end
      pmd_pkg::RD_COL, pmd_pkg::RD_WAIT: begin
        s_nxt.ras_b     = 1'b0;
        s_nxt.cas_b     = '0;
        s_nxt.dram_addr = {s_nxt.req.col[`PMD_COL_W-1:2], s_nxt.req.col[1:0] + s_nxt.word};
      end
      pmd_pkg::WR_CAS, pmd_pkg::WR_HOLD, pmd_pkg::PG_CAS: begin
        // Byte lanes strobed alone, so a partial store costs nothing extra
        s_nxt.ras_b     = 1'b0;
        s_nxt.cas_b     = ~s_nxt.req.be;
        s_nxt.we_b      = 1'b0;
        s_nxt.dq_oe     = 1'b1;
        s_nxt.dram_addr = s_nxt.req.col;
      end
      pmd_pkg::REF_CAS: s_nxt.cas_b = '0;
      pmd_pkg::REF_RAS, pmd_pkg::REF_HOLD: begin
        s_nxt.ras_b = 1'b0;
        s_nxt.cas_b = '0;
      end
      default: s_nxt.ras_b = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r       <= '0;
      s_r.st    <= pmd_pkg::IDLE;
      s_r.ras_b <= 1'b1;
      s_r.cas_b <= '1;
      s_r.we_b  <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rd_data    = s_r.rd_data;
  assign rd_valid   = s_r.rd_valid;
  assign rd_last    = s_r.rd_last;
  assign wr_ack     = (s_r.st == pmd_pkg::WR_END);
  assign busy       = (s_r.st != pmd_pkg::IDLE) && (s_r.st != pmd_pkg::PAGE_IDLE);
  assign ras_b      = s_r.ras_b;
  assign cas_b      = s_r.cas_b;
  assign we_b       = s_r.we_b;
  assign dram_addr  = s_r.dram_addr;
  assign dram_dq_o  = s_r.req.wdata;
  assign dram_dq_oe = s_r.dq_oe;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  logic rd_take;
  logic pg_take;
  assign rd_take = (s_r.st == pmd_pkg::IDLE) && !s_r.ref_pend && rd_req;
  assign pg_take = (s_r.st == pmd_pkg::PAGE_IDLE) && !s_r.ref_pend && !rd_req && wr_req;

  a_read_ras_delay:
    assert property (rd_take |=> !ras_b) else $error("RAS not low one clock after read");
  a_read_data_time:
    assert property (rd_take |=> ##3 rd_valid) else $error("Read data not three clocks after RAS");
  a_read_tail_pre:
    assert property (rd_valid && rd_last |-> ras_b [*2]) else $error("Read tail precharge short");
  a_single_read_len:
    assert property (rd_take && !quad_req |-> ##6 (s_r.st == pmd_pkg::IDLE)) else $error("Single read not six clocks");
  a_page_idle_ras:
    assert property (wr_ack |=> (s_r.st == pmd_pkg::PAGE_IDLE) && !ras_b) else $error("No page idle after write");
  a_leave_page_pre:
    assert property ((s_r.st == pmd_pkg::PAGE_IDLE) && (s_r.ref_pend || rd_req) |=> ras_b) else $error("RAS kept low");
  a_idle_write_len:
    assert property ((s_r.st == pmd_pkg::IDLE) && !s_r.ref_pend && !rd_req && wr_req |-> (!wr_ack [*4] ##1 wr_ack))
      else $error("Idle write not five clocks");
  a_page_write_len:
    assert property (pg_take && row_hit |-> (!ras_b && !wr_ack) [*2] ##1 (wr_ack && !ras_b))
      else $error("Page write not three clocks");
  a_nonpage_len:
    assert property (pg_take && !row_hit |=> ras_b [*3] ##4 wr_ack) else $error("Non-page write not eight clocks");
  a_rdwr_extra_pre:
    assert property ((s_r.st == pmd_pkg::PAGE_IDLE) && !s_r.ref_pend && rd_req |=> ras_b [*2] ##1 !ras_b)
      else $error("Read after write precharge wrong");
  a_quad_gap:
    assert property (rd_valid && !rd_last |=> !rd_valid [*2] ##1 rd_valid) else $error("Quad gap not two clocks");
  a_refresh_first:
    assert property ((s_r.st == pmd_pkg::PAGE_IDLE) && s_r.ref_pend |=> ras_b ##2 (cas_b == '0) && ras_b)
      else $error("Refresh not served first");
endmodule

// [testbench/pmd_dram_model.sv]
`timescale 1ns/1ns
`include "pmd_cfg.svh"
module pmd_dram_model (
  input  wire logic                   sys_clk,
  input  wire logic                   ras_b,
  input  wire logic [`PMD_LANES-1:0]  cas_b,
  input  wire logic                   we_b,
  input  wire logic [`PMD_COL_W-1:0]  dram_addr,
  input  wire logic [`PMD_DATA_W-1:0] dram_dq_o,
  input  wire logic                   dram_dq_oe,
  output logic [`PMD_DATA_W-1:0]      dram_dq_i
);
  logic [31:0] mem [logic [19:0]];
  logic [9:0]  row = '0;
  logic [9:0]  col = '0;
  logic        ras_q = 1'b1;
  logic        cas_q = 1'b1;
  initial dram_dq_i = '0;
  // Mid-cycle sampling, all registered strobes settled
  always @(negedge sys_clk) begin
    if (ras_q && !ras_b && &cas_b) row = dram_addr;
    if (cas_q && !(&cas_b) && !ras_b) begin
      col = dram_addr;
      if (!mem.exists({row, col})) mem[{row, col}] = ~{12'h000, row, col};
      for (int l = 0; l < 4; l++)
        if (!we_b && dram_dq_oe && !cas_b[l]) mem[{row, col}][8*l +: 8] = dram_dq_o[8*l +: 8];
    end
    // Undriven bus toggles so a stale word never passes
    if (!ras_b && !(&cas_b) && we_b) dram_dq_i <= mem[{row, col}];
    else dram_dq_i <= ~dram_dq_i;
    ras_q = ras_b;
    cas_q = &cas_b;
  end
endmodule

// [testbench/page_mode_dram_sequencer_tb_top.sv]
`timescale 1ns/1ns
`include "pmd_cfg.svh"
module page_mode_dram_sequencer_tb_top;
  typedef struct packed {
    logic        wr;
    logic        last;
    logic [31:0] data;
    logic [31:0] cyc;
  } pmd_note_t;
  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        rd_req = 1'b0;
  logic        wr_req = 1'b0;
  logic        quad_req = 1'b0;
  logic        page_hint_output = 1'b0;
  logic [19:0] cpu_addr = '0;
  logic [31:0] cpu_wdata = '0;
  logic [3:0]  cpu_be = '0;
  logic [31:0] rd_data, dram_dq_o, dram_dq_i;
  logic [3:0]  cas_b;
  logic [9:0]  dram_addr;
  logic        rd_valid, rd_last, wr_ack, busy, ras_b, we_b, dram_dq_oe;
  logic        pg = 1'b0;
  logic [9:0]  lrow = '0;
  int          err_count = 0;
  int          compares = 0;
  int          cbr = 0;
  logic [31:0] cyc = '0;
  logic [31:0] sh [logic [19:0]];
  pmd_note_t   notes [$];
  pmd_note_t   nt;

  pmd_sequencer i_pmd_sequencer (.sys_clk, .rst_b, .rd_req, .wr_req, .quad_req, .page_hint_output,
    .cpu_addr, .cpu_wdata, .cpu_be, .rd_data, .rd_valid, .rd_last, .wr_ack, .busy, .ras_b, .cas_b,
    .we_b, .dram_addr, .dram_dq_i, .dram_dq_o, .dram_dq_oe);
  pmd_dram_model i_pmd_dram_model (.sys_clk, .ras_b, .cas_b, .we_b, .dram_addr, .dram_dq_o,
    .dram_dq_oe, .dram_dq_i);

  always #5 sys_clk = ~sys_clk;

  task check(input string w, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %0s expected %h seen %h", w, e, s);
    end
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Run needs about 1900 cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 32'h1;
    if (cyc == 32'h1388) begin
      err_count++;
      stop_test();
    end
  end

  function automatic logic [31:0] exp_rd(input logic [19:0] a);
    return sh.exists(a) ? sh[a] : ~{12'h000, a};
  endfunction

  always @(negedge sys_clk) begin
    if (rst_b && (rd_valid === 1'b1 || wr_ack === 1'b1)) begin
      if (notes.size() == 0) check("note", 32'h1, 32'h0);
      else begin
        nt = notes.pop_front();
        check("kind", {31'h0, wr_ack}, {31'h0, nt.wr});
        check("cycle", cyc, nt.cyc);
        if (!nt.wr) begin
          check("data", rd_data, nt.data);
          check("last", {31'h0, rd_last}, {31'h0, nt.last});
        end
      end
    end
    if (ras_b === 1'b1 && cas_b !== 4'hF) cbr++;
  end

  task wr(input logic [19:0] a, input logic [3:0] be, input logic h);
    logic [31:0] d;
    logic [31:0] k;
    int          n;
    d = $urandom;
    k = !pg ? 32'h4 : (h && a[19:10] == lrow) ? 32'h2 : 32'h7;
    @(negedge sys_clk);
    wr_req = 1'b1;
    cpu_addr = a;
    cpu_wdata = d;
    cpu_be = be;
    page_hint_output = h;
    notes.push_back('{1'b1, 1'b0, 32'h0, cyc + k});
    if (!sh.exists(a)) sh[a] = ~{12'h000, a};
    for (int l = 0; l < 4; l++)
      if (be[l]) sh[a][8*l +: 8] = d[8*l +: 8];
    n = 0;
    while (wr_ack !== 1'b1 && n < 30) begin
      @(negedge sys_clk);
      n++;
      if (k == 32'h2 || (k == 32'h7 && n <= 3))
        check("ras", {31'h0, ras_b}, {31'h0, k != 32'h2});
    end
    if (n == 30) check("ack", 32'h0, 32'h1);
    @(negedge sys_clk);
    wr_req = 1'b0;
    check("ras", {31'h0, ras_b}, 32'h0);
    check("busy", {31'h0, busy}, 32'h0);
    pg = 1'b1;
    lrow = a[19:10];
  endtask

  task rd(input logic [19:0] a, input logic q);
    logic [31:0] k;
    int          n;
    k = pg ? 32'h6 : 32'h4;
    @(negedge sys_clk);
    rd_req = 1'b1;
    cpu_addr = a;
    quad_req = q;
    for (int i = 0; i < (q ? 4 : 1); i++)
      notes.push_back('{1'b0, i == (q ? 3 : 0), exp_rd({a[19:2], a[1:0] + 2'(i)}), cyc + k + 32'(3 * i)});
    n = 0;
    while (!(rd_valid === 1'b1 && rd_last === 1'b1) && n < 40) begin
      @(negedge sys_clk);
      n++;
      if (n == 1 || n == 2) check("ras", {31'h0, ras_b}, {31'h0, pg});
    end
    if (n == 40) check("read", 32'h0, 32'h1);
    rd_req = 1'b0;
    pg = 1'b0;
    // Tail precharge must finish before the next strobe is counted as taken
    while (busy === 1'b1 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
  endtask

  initial begin
    int          c;
    logic [19:0] a;
    void'($urandom(32'h952677A8));
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (12) @(negedge sys_clk);
    wr(20'h01004, 4'hF, 1'b1);
    rd(20'h01004, 1'b0);
    rd(20'h01004, 1'b0);
    $display("test single done");
    // Four buffered stores to one row, partial lanes, then wrapped quad
    for (int i = 0; i < 4; i++) wr({10'h05A, 8'h11, 2'(i)}, 4'($urandom % 15 + 1), 1'b1);
    rd({10'h05A, 8'h11, 2'h1}, 1'b1);
    $display("test page done");
    // Row change and low hint both force the slow path
    wr(20'h0A000, 4'hF, 1'b1);
    wr(20'h0B000, 4'hF, 1'b1);
    wr(20'h0B004, 4'hF, 1'b0);
    wr(20'h0B008, 4'hC, 1'b1);
    rd(20'h0A000, 1'b0);
    rd(20'h0B004, 1'b0);
    $display("test miss done");
    wr(20'h01008, 4'h3, 1'b1);
    c = cbr;
    repeat (1600) @(negedge sys_clk);
    check("refresh", {31'h0, cbr > c}, 32'h1);
    check("ras", {31'h0, ras_b}, 32'h1);
    pg = 1'b0;
    rd(20'h01004, 1'b0);
    $display("test refresh done");
    for (int i = 0; i < 16; i++) begin
      a = {9'h0F0, 1'($urandom), 10'($urandom)};
      if ($urandom % 3 == 0) rd(a, 1'($urandom));
      else wr(a, 4'($urandom % 15 + 1), 1'($urandom));
    end
    check("pending", 32'(notes.size()), 32'h0);
    $display("test random done");
    stop_test();
  end
endmodule
